// ---- verif/ebt_ext_dev.sv ----
`timescale 1ns/10ps
module ebt_ext_dev (
  // Controller side
  input wire logic clk_in,
  input wire logic [2:0] cs_n_in,
  input wire logic oe_n_in,
  input wire logic [1:0] wbe_n_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic [7:0] stall_in,
  // Device answers
  output logic [15:0] data_out,
  output logic wait_n_out
);
  logic [15:0] mem [logic [23:0]];
  logic [15:0] last_q = 16'h0000;
  int cnt = 0;
  wire logic sel = ~&cs_n_in;
  assign wait_n_out = !(sel && cnt < stall_in);
  // Released bus toggles so a stale sample never passes as data
  always_comb data_out = (sel && !oe_n_in) ? mem[addr_in] : ~last_q;
  always @(posedge clk_in) begin
    last_q <= data_out;
    cnt <= sel ? cnt + 1 : 0;
    if (sel && !wbe_n_in[0]) mem[addr_in][7:0] <= data_in[7:0];
    if (sel && !wbe_n_in[1]) mem[addr_in][15:8] <= data_in[15:8];
  end
endmodule // ebt_ext_dev

// ---- verif/ebt_io_bank_ctrl_props.sv ----
`timescale 1ns/10ps
module ebt_io_bank_ctrl_props #(
  parameter int NUM_BANKS = 3
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Register bus
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  // Requests and pins
  input wire logic req_valid_in,
  input wire logic req_ready_out,
  input wire logic resp_valid_out,
  input wire logic resp_miss_out,
  input wire logic ext_wait_n_in,
  input wire logic ext_data_oe_out,
  input wire logic [NUM_BANKS-1:0] ext_chip_select_n_out,
  input wire logic output_enable_n_out,
  input wire logic [1:0] write_byte_enable_n_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire logic idle = &ext_chip_select_n_out;
  wire logic strobe = !output_enable_n_out || write_byte_enable_n_out != 2'h3;
  property p_one_cs; $onehot0(~ext_chip_select_n_out); endproperty
  a_one_cs: assert property (p_one_cs) else $error("two selects low");
  property p_strobe_cs; strobe |-> !idle; endproperty
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe outside select");
  property p_rd_wr; !output_enable_n_out |-> write_byte_enable_n_out == 2'h3 && !ext_data_oe_out;
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("read and write strobes mixed");
  property p_take; req_valid_in && req_ready_out |=> !idle || (resp_valid_out && resp_miss_out);
  endproperty
  a_take: assert property (p_take) else $error("no action after take");
  property p_busy; !idle |-> !req_ready_out; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_pulse; resp_valid_out |=> !resp_valid_out; endproperty
  a_pulse: assert property (p_pulse) else $error("response too long");
  property p_hold; $rose(output_enable_n_out) |-> !idle; endproperty
  a_hold: assert property (p_hold) else $error("select hold missing");
  property p_end; $rose(idle) |-> resp_valid_out && !resp_miss_out; endproperty
  a_end: assert property (p_end) else $error("no response at end");
  property p_wait; (!output_enable_n_out && !ext_wait_n_in) [*4] |=> !output_enable_n_out;
  endproperty
  a_wait: assert property (p_wait) else $error("wait ignored");
  property p_rd_bus; hsel_in && hready_in && htrans_in[1] && !hwrite_in |=>
    !hreadyout_out ##1 hreadyout_out; endproperty
  a_rd_bus: assert property (p_rd_bus) else $error("register read timing");
endmodule // ebt_io_bank_ctrl_props
bind ebt_io_bank_ctrl ebt_io_bank_ctrl_props #(.NUM_BANKS(NUM_BANKS)) u_props (
  .core_clk_in, .rst_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out,
  .req_valid_in, .req_ready_out, .resp_valid_out, .resp_miss_out, .ext_wait_n_in,
  .ext_data_oe_out, .ext_chip_select_n_out, .output_enable_n_out, .write_byte_enable_n_out);

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic clk, rst, hsel, hwrite, hrdy, req_valid, req_ready, resp_valid, resp_miss;
  logic oe_n, dat_oe, wait_n, miss, hresp;
  logic [1:0] htrans, wbe_n;
  logic [2:0] cs_n;
  logic [7:0] stall;
  logic [15:0] xin, xout, rdata;
  logic [15:0] lf = 16'he602;
  logic [23:0] xaddr;
  logic [31:0] haddr, hwdata, hrdata;
  ebt_pkg::ebt_req_type req;
  int n_errors, checks_done;
  ebt_io_bank_ctrl u_dut (.core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
    .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
    .resp_valid_out(resp_valid), .resp_miss_out(resp_miss), .resp_rdata_out(rdata),
    .ext_wait_n_in(wait_n), .ext_data_in(xin), .ext_data_out(xout), .ext_data_oe_out(dat_oe),
    .ext_addr_out(xaddr), .ext_chip_select_n_out(cs_n), .output_enable_n_out(oe_n),
    .write_byte_enable_n_out(wbe_n));
  ebt_ext_dev u_dev (.clk_in(clk), .cs_n_in(cs_n), .oe_n_in(oe_n), .wbe_n_in(wbe_n),
    .addr_in(xaddr), .data_in(xout), .stall_in(stall), .data_out(xin), .wait_n_out(wait_n));
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int cyc(int n, int m);
    return (m == 0) ? n + 1 : n * (1 << m) + (1 << (m + 3));
  endfunction
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Level is looked at just before the rising edge that samples it
  task automatic await(bit k);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 9000) begin
        chk("timeout", 0, 1);
        close_out();
      end
    end while ((k ? req_ready : hrdy) !== 1'b1);
    @(posedge clk);
  endtask
  task automatic ahb(logic w, logic [15:0] a, logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {16'h0000, a};
    await(0);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    await(0);
    r = hrdata;
  endtask
  task automatic acc(logic w, logic [1:0] be, logic [23:0] a, logic [15:0] d,
                     output int ac, output int hc, output logic [2:0] cs);
    int n;
    req_valid <= 1'b1;
    req <= {w, be, a, d};
    await(1);
    req_valid <= 1'b0;
    ac = 0;
    hc = 0;
    cs = 3'h7;
    n = 0;
    while (resp_valid !== 1'b1) begin
      @(negedge clk);
      n++;
      if (oe_n === 1'b0 || wbe_n !== 2'h3) ac++;
      else if (cs_n !== 3'h7) hc++;
      if (cs_n !== 3'h7) cs = cs_n;
      if (n > 9000) begin
        chk("response", 0, 1);
        close_out();
      end
    end
    miss = resp_miss;
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    logic [31:0] r, cfg;
    logic [23:0] a;
    logic [7:0] bp, lp;
    logic [2:0] cs;
    logic [2:0] act;
    int ac, hc, m, bk;
    rst = 1'b1;
    {hsel, htrans, hwrite, haddr, hwdata, req_valid, req, stall} = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    ahb(0, 16'h5000, 32'h0000_0000, r);
    chk("bank0 reset", r, 32'h0000_0000);
    chk("hresp", hresp, 32'h0000_0000);
    ahb(0, 16'h5100, 32'h0000_0000, r);
    chk("unmapped", r, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      lf = lfsr(lf);
      bk = i % 3;
      m = i / 3;
      bp = 8'(16 * bk);
      lp = bp + 8'h03;
      a = i[0] ? {lp, 16'hffff} : {bp, 16'h0000};
      // Reads need three strobe cycles to get data through the pin synchroniser
      act = (m == 0) ? (lf[2:0] | 3'h2) : lf[2:0];
      cfg = {2'h0, lp, 2'h0, bp, act, lf[5:3], 6'h00};
      ahb(1, 16'h500c, 32'(m), r);
      ahb(0, 16'h500c, 32'h0000_0000, r);
      chk("ctrl", r, 32'(m));
      ahb(1, 16'h5000 + 16'(4 * bk), cfg | 32'hc030_003f, r);
      ahb(0, 16'h5000 + 16'(4 * bk), 32'h0000_0000, r);
      chk("cfg", r, cfg);
      acc(1, 2'h3, a, lf, ac, hc, cs);
      chk("act", ac, cyc(act, m));
      chk("hold", hc, cyc(lf[5:3], m));
      chk("bank", cs, 3'(~(3'h1 << bk)));
      acc(0, 2'h3, a, 16'h0000, ac, hc, cs);
      chk("rdata", rdata, lf);
    end
    ahb(1, 16'h500c, 32'h0000_0000, r);
    ahb(1, 16'h5000, 32'h00c0_0000, r);
    acc(1, 2'h3, 24'h00_0010, 16'h1234, ac, hc, cs);
    chk("act min", ac, 1);
    acc(1, 2'h1, 24'h00_0010, 16'habcd, ac, hc, cs);
    ahb(1, 16'h5000, 32'h00c0_0400, r);
    acc(0, 2'h3, 24'h00_0010, 16'h0000, ac, hc, cs);
    chk("lanes", rdata, 32'h0000_12cd);
    stall <= 8'h0a;
    acc(0, 2'h3, 24'h00_0010, 16'h0000, ac, hc, cs);
    chk("wait", ac >= 10 && ac <= 16, 1);
    chk("wait data", rdata, 32'h0000_12cd);
    stall <= 8'h00;
    acc(0, 2'h3, 24'h24_0000, 16'h0000, ac, hc, cs);
    chk("miss", {cs, miss}, 4'hf);
    ahb(0, 16'h5010, 32'h0000_0000, r);
    chk("status", r, 32'h0000_1612);
    close_out();
  end
endmodule // tb_top

// ---- verilog/ebt_consts.svh ----
`ifndef EBT_CONSTS_SVH
`define EBT_CONSTS_SVH
`define EBT_OFS_BANK0 16'h5000
`define EBT_OFS_BANK1 16'h5004
`define EBT_OFS_BANK2 16'h5008
`define EBT_OFS_CTRL 16'h500C
`define EBT_OFS_STAT 16'h5010
`define EBT_LAST_HI 29
`define EBT_LAST_LO 22
`define EBT_BASE_HI 19
`define EBT_BASE_LO 12
`define EBT_ACT_HI 11
`define EBT_ACT_LO 9
`define EBT_HOLD_HI 8
`define EBT_HOLD_LO 6
`define EBT_TM_HI 2
`define EBT_TM_LO 0
`define EBT_LOW_FILL 16'hFFFF
`define EBT_LOW_ZERO 16'h0000
`define EBT_TM_EXTRA 3'h3
`define EBT_HTRANS_NONSEQ 2'h2
`define EBT_HTRANS_SEQ 2'h3
`define EBT_HRESP_OKAY 1'h0
`define EBT_CNT_ONE 12'h001
`define EBT_CFG_RESET 22'h00_0000
`endif

// ---- verilog/ebt_io_bank_ctrl.sv ----
`timescale 1ns/10ps
`include "ebt_consts.svh"
module ebt_io_bank_ctrl #(
  parameter int NUM_BANKS = 3,
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // Access request from the system side
  input wire logic req_valid_in,
  input wire ebt_pkg::ebt_req_type req_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output logic resp_miss_out,
  output logic [15:0] resp_rdata_out,
  // External bus pins
  input wire logic ext_wait_n_in,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] ext_data_out,
  output logic ext_data_oe_out,
  output logic [23:0] ext_addr_out,
  output logic [NUM_BANKS-1:0] ext_chip_select_n_out,
  output logic output_enable_n_out,
  output logic [1:0] write_byte_enable_n_out
);

  // Cycle count for a timing code under a given multiplier
  function automatic logic [CNT_W-1:0] code_cycles(
    input logic [2:0] code,
    input logic [2:0] mult
  );
    logic [CNT_W-1:0] wide_code;
    wide_code = CNT_W'(code);
    if (mult == 3'h0) begin
      code_cycles = wide_code + `EBT_CNT_ONE;
    end else begin
      // Shift amount widened so multipliers above four do not wrap
      code_cycles = CNT_W'((wide_code << mult)
        + (`EBT_CNT_ONE << (4'(mult) + 4'(`EBT_TM_EXTRA))));
    end
  endfunction

  // Register file view of one bank
  function automatic logic [31:0] bank_word(
    input ebt_pkg::ebt_bank_cfg_type cfg
  );
    bank_word = 32'h0000_0000;
    bank_word[`EBT_LAST_HI:`EBT_LAST_LO] = cfg.last_ptr;
    bank_word[`EBT_BASE_HI:`EBT_BASE_LO] = cfg.base_ptr;
    bank_word[`EBT_ACT_HI:`EBT_ACT_LO] = cfg.act_time;
    bank_word[`EBT_HOLD_HI:`EBT_HOLD_LO] = cfg.hold_time;
  endfunction

  ebt_pkg::ebt_bank_cfg_type bank_cfg [NUM_BANKS];
  ebt_pkg::ebt_state_type state;
  ebt_pkg::ebt_state_type next_state;
  ebt_pkg::ebt_req_type cur_req;
  logic [2:0] timing_multiplier;
  logic [2:0] mult_active;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [NUM_BANKS-1:0] cur_sel;
  logic wait_meta;
  logic ext_wait_n;
  logic [15:0] data_meta;
  logic [15:0] data_sync;
  logic last_miss;
  logic [31:0] access_count;

  // AHB address-phase capture
  logic dp_write;
  logic dp_read;
  logic rd_wait;
  logic [15:0] dp_addr;
  wire addr_phase = hsel_in && hready_in
    && (htrans_in == `EBT_HTRANS_NONSEQ || htrans_in == `EBT_HTRANS_SEQ);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 16'h0000;
    end else if (hready_in || !hreadyout_out) begin
      dp_write <= addr_phase && hwrite_in;
      dp_read <= addr_phase && !hwrite_in;
      dp_addr <= addr_phase ? haddr_in[15:0] : dp_addr;
    end
  end

  // Reads take one wait state so hrdata comes from a flop and sees the
  // effect of a write in the previous data phase.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= dp_read && !rd_wait;
    end
  end

  assign hreadyout_out = !(dp_read && !rd_wait);
  assign hresp_out = `EBT_HRESP_OKAY;

  wire wr_bank0 = dp_write && dp_addr == `EBT_OFS_BANK0;
  wire wr_bank1 = dp_write && dp_addr == `EBT_OFS_BANK1;
  wire wr_bank2 = dp_write && dp_addr == `EBT_OFS_BANK2;
  wire wr_ctrl = dp_write && dp_addr == `EBT_OFS_CTRL;
  wire [NUM_BANKS-1:0] wr_bank = {wr_bank2, wr_bank1, wr_bank0};

  // Each bank register only touches its own configuration
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank_reg
      always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
          bank_cfg[gi] <= `EBT_CFG_RESET;
        end else if (wr_bank[gi]) begin
          bank_cfg[gi].last_ptr <= hwdata_in[`EBT_LAST_HI:`EBT_LAST_LO];
          bank_cfg[gi].base_ptr <= hwdata_in[`EBT_BASE_HI:`EBT_BASE_LO];
          bank_cfg[gi].act_time <= hwdata_in[`EBT_ACT_HI:`EBT_ACT_LO];
          bank_cfg[gi].hold_time <= hwdata_in[`EBT_HOLD_HI:`EBT_HOLD_LO];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timing_multiplier <= 3'h0;
    end else if (wr_ctrl) begin
      timing_multiplier <= hwdata_in[`EBT_TM_HI:`EBT_TM_LO];
    end
  end

  wire busy = state != ebt_pkg::EBT_IDLE;
  wire [31:0] stat_word = {access_count[23:0], 3'h0, last_miss, cur_sel, busy};
  wire [31:0] ctrl_word = {29'h0000_0000, timing_multiplier};
  wire [31:0] rd_mux =
    (dp_addr == `EBT_OFS_BANK0) ? bank_word(bank_cfg[0]) :
    (dp_addr == `EBT_OFS_BANK1) ? bank_word(bank_cfg[1]) :
    (dp_addr == `EBT_OFS_BANK2) ? bank_word(bank_cfg[2]) :
    (dp_addr == `EBT_OFS_CTRL) ? ctrl_word :
    (dp_addr == `EBT_OFS_STAT) ? stat_word : 32'h0000_0000;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (dp_read && !rd_wait) begin
      hrdata_out <= rd_mux;
    end
  end

  // Two-flop synchronisers for the pins
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_meta <= 1'b1;
      ext_wait_n <= 1'b1;
      data_meta <= 16'h0000;
      data_sync <= 16'h0000;
    end else begin
      wait_meta <= ext_wait_n_in;
      ext_wait_n <= wait_meta;
      data_meta <= ext_data_in;
      data_sync <= data_meta;
    end
  end

  // Address window decode, lowest bank wins on overlap
  logic [NUM_BANKS-1:0] hit;
  logic [NUM_BANKS-1:0] hit_oh;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_decode
      wire [23:0] start_addr = {bank_cfg[gi].base_ptr, `EBT_LOW_ZERO};
      wire [23:0] end_addr = {bank_cfg[gi].last_ptr, `EBT_LOW_FILL};
      assign hit[gi] = req_in.addr >= start_addr && req_in.addr <= end_addr;
      if (gi == 0) begin : g_first
        assign hit_oh[gi] = hit[gi];
      end else begin : g_rest
        assign hit_oh[gi] = hit[gi] && !(|hit[gi-1:0]);
      end
    end
  endgenerate

  wire [2:0] sel_act = hit_oh[0] ? bank_cfg[0].act_time :
    hit_oh[1] ? bank_cfg[1].act_time : bank_cfg[2].act_time;
  logic [2:0] cur_hold;
  assign req_ready_out = state == ebt_pkg::EBT_IDLE;
  wire take = req_valid_in && req_ready_out;
  wire start = take && (|hit);
  wire last_cycle = cnt == `EBT_CNT_ONE;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ebt_pkg::EBT_IDLE: begin
        if (start) begin
          next_state = ebt_pkg::EBT_STROBE;
          next_cnt = code_cycles(sel_act, timing_multiplier);
        end
      end
      ebt_pkg::EBT_STROBE: begin
        if (!last_cycle) begin
          next_cnt = cnt - `EBT_CNT_ONE;
        end else if (ext_wait_n) begin
          next_state = ebt_pkg::EBT_HOLD;
          next_cnt = code_cycles(cur_hold, mult_active);
        end
      end
      ebt_pkg::EBT_HOLD: begin
        if (last_cycle) begin
          next_state = ebt_pkg::EBT_IDLE;
        end else begin
          next_cnt = cnt - `EBT_CNT_ONE;
        end
      end
      default: begin
        next_state = ebt_pkg::EBT_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ebt_pkg::EBT_IDLE;
      cnt <= `EBT_CNT_ONE;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Access context, multiplier frozen for the whole access
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_req <= '0;
      cur_sel <= '0;
      cur_hold <= 3'h0;
      mult_active <= 3'h0;
    end else if (start) begin
      cur_req <= req_in;
      cur_sel <= hit_oh;
      cur_hold <= hit_oh[0] ? bank_cfg[0].hold_time :
        hit_oh[1] ? bank_cfg[1].hold_time : bank_cfg[2].hold_time;
      mult_active <= timing_multiplier;
    end
  end

  // Pin outputs from flops, set from the next state
  wire nx_strobe = next_state == ebt_pkg::EBT_STROBE;
  wire nx_active = next_state != ebt_pkg::EBT_IDLE;
  wire nx_write = start ? req_in.write : cur_req.write;
  wire [NUM_BANKS-1:0] nx_sel = start ? hit_oh : cur_sel;
  wire [1:0] nx_be = start ? req_in.byte_en : cur_req.byte_en;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_chip_select_n_out <= '1;
      output_enable_n_out <= 1'b1;
      write_byte_enable_n_out <= 2'h3;
      ext_data_oe_out <= 1'b0;
    end else begin
      ext_chip_select_n_out <= nx_active ? ~nx_sel : '1;
      output_enable_n_out <= !(nx_strobe && !nx_write);
      write_byte_enable_n_out <= (nx_strobe && nx_write) ? ~nx_be : 2'h3;
      ext_data_oe_out <= nx_active && nx_write;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_addr_out <= 24'h00_0000;
      ext_data_out <= 16'h0000;
    end else if (start) begin
      ext_addr_out <= req_in.addr;
      ext_data_out <= req_in.wdata;
    end
  end

  // Read data is taken as the strobe ends; the sync delay means the
  // device must present data two clocks before the strobe closes.
  wire strobe_end = state == ebt_pkg::EBT_STROBE && next_state == ebt_pkg::EBT_HOLD;
  wire hold_end = state == ebt_pkg::EBT_HOLD && next_state == ebt_pkg::EBT_IDLE;
  wire miss = take && !(|hit);

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_rdata_out <= 16'h0000;
    end else if (strobe_end && !cur_req.write) begin
      resp_rdata_out <= data_sync;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      resp_miss_out <= 1'b0;
      last_miss <= 1'b0;
      access_count <= 32'h0000_0000;
    end else begin
      resp_valid_out <= hold_end || miss;
      resp_miss_out <= miss;
      last_miss <= miss ? 1'b1 : (start ? 1'b0 : last_miss);
      access_count <= access_count + (hold_end ? 32'h0000_0001 : 32'h0000_0000);
    end
  end

endmodule // ebt_io_bank_ctrl

// ---- verilog/ebt_pkg.sv ----
package ebt_pkg;
  typedef enum logic [2:0] {
    EBT_IDLE = 3'h1,
    EBT_STROBE = 3'h2,
    EBT_HOLD = 3'h4
  } ebt_state_type;
  typedef struct packed {
    logic [7:0] last_ptr;
    logic [7:0] base_ptr;
    logic [2:0] act_time;
    logic [2:0] hold_time;
  } ebt_bank_cfg_type;
  typedef struct packed {
    logic write;
    logic [1:0] byte_en;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ebt_req_type;
endpackage
